// ==== logic/tdmso_defines.vh ====
`ifndef TDMSO_DEFINES_VH
`define TDMSO_DEFINES_VH

// Stream rate codes: 2, 4, 8, 16 and 32 Mbps.
`define TDMSO_RATE_2M        3'h0
`define TDMSO_RATE_4M        3'h1
`define TDMSO_RATE_8M        3'h2
`define TDMSO_RATE_16M       3'h3
`define TDMSO_RATE_32M       3'h4

// Frame length in quarter bits at 2 Mbps; doubles with each rate step.
`define TDMSO_FRAME_QTR_2M   15'h0400
// Channels per frame at 2 Mbps; doubles with each rate step.
`define TDMSO_CHANS_2M       10'h020
// Eighth ticks per quarter bit at 2 Mbps; halves with each rate step.
`define TDMSO_EIGHTHS_2M     5'h10

// Default sample point index inside a bit cell (3/4 position).
`define TDMSO_SMP_DEFAULT    2'h2

// Largest advancement in core cycles, per rate class.
`define TDMSO_ADV_MAX_LOW    3'h6
`define TDMSO_ADV_MAX_32M    3'h3

// Control stream timing in kHz; the pacing accumulator wraps past the
// core rate, which keeps the average bit rate exact.
`define TDMSO_CLK_KHZ        18'h3_D090
`define TDMSO_CTRL_RATE_KHZ  18'h0_4000
`define TDMSO_CTRL_WRAP      (`TDMSO_CLK_KHZ - `TDMSO_CTRL_RATE_KHZ)

`endif

// ==== logic/tdmso_in_lane.v ====
`include "tdmso_defines.vh"
`default_nettype none

module tdmso_in_lane (
  input  wire       clk_i,          // Core clock.
  input  wire       rst_n_i,        // Synchronous reset, active low.
  input  wire       frame_start_i,  // One-cycle frame boundary pulse.
  input  wire       eighth_tick_i,  // One eighth of a link clock period.
  input  wire       rx_bit_i,       // Synchronised serial input.
  input  wire [2:0] rate_i,         // Stream rate code.
  input  wire [8:0] chan_delay_i,   // Channel delay.
  input  wire [4:0] bit_delay_i,    // Bit offset field.
  input  wire       sample_mode_i,  // Sample point select flag.
  output reg  [7:0] byte_o,         // Received channel byte.
  output reg  [8:0] chan_o,         // Channel number of byte_o.
  output reg        byte_valid_o    // One-cycle strobe for byte_o.
);

  reg  [2:0]  rate_q;
  reg  [14:0] dly_q;
  reg  [1:0]  smp_q;
  reg  [4:0]  ecnt_q;
  reg  [14:0] qpos_q;
  reg  [6:0]  sh_q;
  wire [9:0]  nch;
  wire [8:0]  cd;
  wire [14:0] fq;
  wire [14:0] p;
  wire        qtick;

  assign nch = `TDMSO_CHANS_2M << rate_i;
  // Clamp to the last channel of the frame at this rate.
  assign cd  = ({1'b0, chan_delay_i} >= nch) ? nch[8:0] - 9'h001
                                             : chan_delay_i;
  assign fq  = `TDMSO_FRAME_QTR_2M << rate_q;
  assign qtick = eighth_tick_i &&
                 (ecnt_q == ((`TDMSO_EIGHTHS_2M >> rate_q) - 5'h01));
  // Position inside the delayed frame, in quarter bits.
  assign p   = (qpos_q >= dly_q) ? qpos_q - dly_q
                                 : qpos_q + fq - dly_q;

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      rate_q       <= `TDMSO_RATE_2M;
      dly_q        <= 15'h0000;
      smp_q        <= `TDMSO_SMP_DEFAULT;
      ecnt_q       <= 5'h00;
      qpos_q       <= 15'h0000;
      sh_q         <= 7'h00;
      byte_o       <= 8'h00;
      chan_o       <= 9'h000;
      byte_valid_o <= 1'b0;
    end
    else
    begin
      byte_valid_o <= 1'b0;
      if (frame_start_i)
      begin
        // New settings apply only from a frame boundary.
        rate_q <= rate_i;
        qpos_q <= 15'h0000;
        ecnt_q <= 5'h00;
        if (sample_mode_i)
        begin
          dly_q <= {1'b0, cd, bit_delay_i[4:2], 2'b00};
          smp_q <= bit_delay_i[1:0] + 2'h2;
        end
        else
        begin
          dly_q <= {1'b0, cd, 5'h00} + {10'h000, bit_delay_i};
          smp_q <= `TDMSO_SMP_DEFAULT;
        end
      end
      else if (qtick)
      begin
        ecnt_q <= 5'h00;
        qpos_q <= (qpos_q == fq - 15'h0001) ? 15'h0000
                                            : qpos_q + 15'h0001;
        if (p[1:0] == smp_q)
        begin
          sh_q <= {sh_q[5:0], rx_bit_i};
          if (p[4:2] == 3'h7)
          begin
            byte_o       <= {sh_q, rx_bit_i};
            chan_o       <= p[13:5];
            byte_valid_o <= 1'b1;
          end
        end
      end
      else if (eighth_tick_i)
      begin
        ecnt_q <= ecnt_q + 5'h01;
      end
    end
  end

endmodule // tdmso_in_lane

`default_nettype wire

// ==== logic/tdmso_port.v ====
`include "tdmso_defines.vh"
`default_nettype none

module tdmso_port #(
  parameter N = 32  // Streams on this port.
) (
  input  wire           clk_i,                      // Core clock.
  input  wire           rst_n_i,                    // Sync reset, low.
  input  wire           master_frame_pulse_in_i,    // Frame pulse, low.
  input  wire           link_clk_i,                 // Link bit clock.
  input  wire [N-1:0]   rx_stream_i,                // Serial inputs.
  input  wire           output_drive_allow_pin_i,   // Drive allow pin.
  input  wire           out_drive_select_i,         // Tri-state select.
  input  wire           sample_point_select_flag_i, // Sample mode.
  input  wire           output_standby_bit_i,       // Standby control.
  input  wire [3*N-1:0] in_rate_i,                  // Input rate codes.
  input  wire [9*N-1:0] in_chan_delay_regs_i,       // Channel delays.
  input  wire [5*N-1:0] in_bit_offset_field_i,      // Bit offsets.
  input  wire [3*N-1:0] out_rate_i,                 // Output rate codes.
  input  wire [2*N-1:0] out_advance_regs_i,         // Advancements.
  input  wire [N-1:0]   tx_bit_i,                   // Bits to send.
  input  wire [N-1:0]   conn_output_on_bit_i,       // Output-on bits.
  output reg  [N-1:0]   serial_outputs_o,           // Serial outputs.
  output reg  [N-1:0]   serial_outputs_oe_o,        // Output enables.
  output reg  [3:0]     tristate_ctrl_streams_o,    // Control streams.
  output wire [8*N-1:0] rx_byte_o,                  // Received bytes.
  output wire [9*N-1:0] rx_chan_o,                  // Byte channels.
  output wire [N-1:0]   rx_valid_o,                 // Byte strobes.
  output reg            frame_pulse_out_o           // Frame start pulse.
);

  localparam SW = N + 4;

  // Three-stage synchronisers; a change counts when stages two and three
  // agree, which rejects single-cycle glitches on the pins.
  reg  [SW-1:0] s1_q;
  reg  [SW-1:0] s2_q;
  reg  [SW-1:0] s3_q;
  reg  [SW-1:0] flt_q;
  wire [SW-1:0] pins;
  wire [SW-1:0] stable;

  assign pins = {out_drive_select_i, output_drive_allow_pin_i,
                 link_clk_i, master_frame_pulse_in_i, rx_stream_i};
  assign stable = (s3_q & ~(s2_q ^ s3_q)) | (flt_q & (s2_q ^ s3_q));

  always @(posedge clk_i)
  begin
    s1_q <= pins;
    s2_q <= s1_q;
    s3_q <= s2_q;
    if (!rst_n_i)
      flt_q <= {SW{1'b1}};
    else
      flt_q <= stable;
  end

  wire [N-1:0] rx_f   = flt_q[N-1:0];
  wire         fp_f   = flt_q[N];
  wire         lclk_f = flt_q[N+1];
  wire         ode_f  = flt_q[N+2];
  wire         sel_s  = (s2_q[N+3] == s3_q[N+3]) ? s3_q[N+3] : flt_q[N+3];

  // Frame boundary and link clock edge detection.
  reg        fp_d_q;
  reg        lclk_d_q;
  reg  [7:0] per_cnt_q;
  reg  [7:0] step_q;
  reg  [7:0] ecnt_q;
  reg        frame_start_q;
  reg        eighth_q;
  wire       lclk_fall = lclk_d_q & ~lclk_f;
  // A link period is one more than the count held at its falling edge.
  wire [7:0] per_len   = per_cnt_q + 8'h01;

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      fp_d_q        <= 1'b1;
      lclk_d_q      <= 1'b1;
      per_cnt_q     <= 8'h00;
      step_q        <= 8'h01;
      ecnt_q        <= 8'h00;
      frame_start_q <= 1'b0;
      eighth_q      <= 1'b0;
    end
    else
    begin
      fp_d_q        <= fp_f;
      lclk_d_q      <= lclk_f;
      frame_start_q <= fp_d_q & ~fp_f;
      eighth_q      <= 1'b0;
      if (lclk_fall)
      begin
        // Re-measure the link period each cycle of the link clock and
        // realign the eighth ticks to its falling edge.
        per_cnt_q <= 8'h00;
        step_q    <= (per_len[7:3] == 5'h00) ? 8'h01
                                             : {3'h0, per_len[7:3]};
        ecnt_q    <= 8'h00;
        eighth_q  <= 1'b1;
      end
      else
      begin
        if (per_cnt_q != 8'hfe)
          per_cnt_q <= per_cnt_q + 8'h01;
        if (ecnt_q >= step_q - 8'h01)
        begin
          ecnt_q   <= 8'h00;
          eighth_q <= 1'b1;
        end
        else
          ecnt_q <= ecnt_q + 8'h01;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < N; g = g + 1)
    begin : g_lane
      tdmso_in_lane u_lane (
        .clk_i         (clk_i),
        .rst_n_i       (rst_n_i),
        .frame_start_i (frame_start_q),
        .eighth_tick_i (eighth_q),
        .rx_bit_i      (rx_f[g]),
        .rate_i        (in_rate_i[3*g+2:3*g]),
        .chan_delay_i  (in_chan_delay_regs_i[9*g+8:9*g]),
        .bit_delay_i   (in_bit_offset_field_i[5*g+4:5*g]),
        .sample_mode_i (sample_point_select_flag_i),
        .byte_o        (rx_byte_o[8*g+7:8*g]),
        .chan_o        (rx_chan_o[9*g+8:9*g]),
        .byte_valid_o  (rx_valid_o[g])
      );
    end
  endgenerate

  // Pipeline tap for an advancement code: the core presents data at the
  // largest advancement and smaller ones are added back as delay.
  function [2:0] adv_tap;
    input [2:0] rate;
    input [1:0] adv;
    begin
      if (rate == `TDMSO_RATE_32M)
        adv_tap = `TDMSO_ADV_MAX_32M - {1'b0, adv};
      else
        adv_tap = `TDMSO_ADV_MAX_LOW - {adv, 1'b0};
    end
  endfunction

  reg [6:0] pipe_q [0:N-1];
  reg [6:0] onp_q  [0:N-1];
  reg [2:0] tap_q  [0:N-1];
  reg       sel_q;
  reg [17:0] div_q;
  reg [2:0] slot_q;
  wire      en_all = ode_f & output_standby_bit_i;
  integer   i;

  always @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      sel_q                   <= sel_s;
      div_q                   <= 18'h0_0000;
      slot_q                  <= 3'h0;
      frame_pulse_out_o       <= 1'b0;
      tristate_ctrl_streams_o <= 4'h0;
      serial_outputs_o        <= {N{1'b1}};
      serial_outputs_oe_o     <= {N{~sel_s}};
      for (i = 0; i < N; i = i + 1)
      begin
        pipe_q[i] <= 7'h7f;
        onp_q[i]  <= 7'h00;
        tap_q[i]  <= `TDMSO_ADV_MAX_LOW;
      end
    end
    else
    begin
      frame_pulse_out_o <= frame_start_q;
      for (i = 0; i < N; i = i + 1)
      begin
        pipe_q[i] <= {pipe_q[i][5:0], tx_bit_i[i]};
        onp_q[i]  <= {onp_q[i][5:0], conn_output_on_bit_i[i]};
        if (frame_start_q)
          tap_q[i] <= adv_tap(out_rate_i[3*i+2 -: 3],
                              out_advance_regs_i[2*i+1 -: 2]);
        if (en_all && onp_q[i][tap_q[i]])
        begin
          serial_outputs_o[i]    <= pipe_q[i][tap_q[i]];
          serial_outputs_oe_o[i] <= 1'b1;
        end
        else
        begin
          serial_outputs_o[i]    <= 1'b1;
          serial_outputs_oe_o[i] <= ~sel_q;
        end
      end
      // Control streams: line j carries streams j, j+4, ... in turn.
      // A phase accumulator paces the bits, so no fractional clock is needed.
      if (div_q >= `TDMSO_CTRL_WRAP)
      begin
        div_q  <= div_q - `TDMSO_CTRL_WRAP;
        slot_q <= slot_q + 3'h1;
        for (i = 0; i < 4; i = i + 1)
          tristate_ctrl_streams_o[i] <= en_all &
            conn_output_on_bit_i[(i + 4 * slot_q) % N];
      end
      else
      begin
        div_q <= div_q + `TDMSO_CTRL_RATE_KHZ;
        if (!en_all)
          tristate_ctrl_streams_o <= 4'h0;
      end
    end
  end

endmodule // tdmso_port

`default_nettype wire

// ==== verification/tdmso_port_chk.sv ====
`default_nettype none
module tdmso_port_chk #(
  parameter N = 32  // Streams.
) (
  input wire logic         clk_i,                    // Clock.
  input wire logic         rst_n_i,                  // Reset.
  input wire logic         master_frame_pulse_in_i,  // Frame pin.
  input wire logic         output_drive_allow_pin_i, // Allow pin.
  input wire logic         out_drive_select_i,       // Select pin.
  input wire logic         output_standby_bit_i,     // Standby.
  input wire logic [N-1:0] conn_output_on_bit_i,     // On bits.
  input wire logic [N-1:0] serial_outputs_o,         // Data.
  input wire logic [N-1:0] serial_outputs_oe_o,      // Enables.
  input wire logic [3:0]   tristate_ctrl_streams_o,  // Ctrl.
  input wire logic [N-1:0] rx_valid_o,               // Strobes.
  input wire logic         frame_pulse_out_o         // Frame out.
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // The allow pin passes a synchroniser, so it is held long enough.
  sequence s_all_on;
    (output_drive_allow_pin_i && output_standby_bit_i &&
     &conn_output_on_bit_i) [*8];
  endsequence
  sequence s_no_allow;
    !output_drive_allow_pin_i [*6];
  endsequence
  a_ctrl_standby: assert property (
    !output_standby_bit_i |=> tristate_ctrl_streams_o == 4'h0)
    else $error("ctrl not low in standby");
  a_data_standby: assert property (
    !output_standby_bit_i |-> ##[1:2] &serial_outputs_o)
    else $error("data not high in standby");
  a_oe_standby: assert property (
    !output_standby_bit_i |-> ##[1:2]
    serial_outputs_oe_o == {N{!out_drive_select_i}})
    else $error("enable wrong in standby");
  a_drive_on: assert property (
    s_all_on |=> &serial_outputs_oe_o)
    else $error("enable low while all on");
  a_allow_off: assert property (
    s_no_allow |-> tristate_ctrl_streams_o == 4'h0 && &serial_outputs_o)
    else $error("outputs live without allow");
  a_frame_single: assert property (
    frame_pulse_out_o |=> !frame_pulse_out_o)
    else $error("frame pulse too long");
  a_frame_follow: assert property (
    $fell(master_frame_pulse_in_i) |-> ##[3:8] frame_pulse_out_o)
    else $error("frame pulse missing");
  a_byte_strobe: assert property (
    rx_valid_o[0] |=> !rx_valid_o[0])
    else $error("byte strobe too long");
endmodule // tdmso_port_chk

bind tdmso_port tdmso_port_chk #(.N(N)) i_tdmso_port_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i),
  .master_frame_pulse_in_i(master_frame_pulse_in_i),
  .output_drive_allow_pin_i(output_drive_allow_pin_i),
  .out_drive_select_i(out_drive_select_i),
  .output_standby_bit_i(output_standby_bit_i),
  .conn_output_on_bit_i(conn_output_on_bit_i),
  .serial_outputs_o(serial_outputs_o),
  .serial_outputs_oe_o(serial_outputs_oe_o),
  .tristate_ctrl_streams_o(tristate_ctrl_streams_o),
  .rx_valid_o(rx_valid_o), .frame_pulse_out_o(frame_pulse_out_o));
`default_nettype wire

// ==== verification/tdmso_tdm_src.sv ====
`default_nettype none
module tdmso_tdm_src #(
  parameter int          N   = 32,                     // Lanes.
  parameter logic [63:0] PAT = 64'h1E2D_3C4B_5A69_7887 // Frame bits.
) (
  output var logic         link_clk_o, // Link clock.
  output var logic         frame_n_o,  // Frame pulse, low.
  output var logic [N-1:0] data_o      // Serial data.
);
  timeunit 1ns;
  timeprecision 1ps;
  int idx = 0;
  // Frames are cut to 64 bits to keep the run short; the receiver
  // restarts its count at every frame pulse, so alignment still shows.
  initial
  begin
    link_clk_o = 1'b1;
    frame_n_o = 1'b1;
    data_o = '1;
    forever
    begin
      #80;
      link_clk_o = 1'b0;
      frame_n_o = idx != 0;
      data_o = {N{PAT[63 - idx]}};
      #80;
      link_clk_o = 1'b1;
      idx = (idx + 1) % 64;
    end
  end
endmodule // tdmso_tdm_src
`default_nettype wire

// ==== verification/tdmso_port_tb.sv ====
`include "tdmso_defines.vh"
`default_nettype none
module tdmso_port_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int N = 32;
  localparam logic [63:0] PAT = 64'h1E2D_3C4B_5A69_7887;
  logic clk = 0, rst_n = 0, sel = 0, allow = 0, stby = 0, smode = 0;
  logic link_clk, frm_n, fp;
  logic [N-1:0] rx, so, soe, vld, tx = '1, on = '1;
  logic [3*N-1:0] orate = '0;
  logic [2*N-1:0] adv = '0;
  logic [9*N-1:0] icd = '0, rchan;
  logic [5*N-1:0] ibo = '0;
  logic [8*N-1:0] rbyte;
  logic [3:0] ctrl, acc;
  logic [7:0] got [4][2];
  int n_errors = 0, checks = 0;
  always #2 clk = ~clk;
  tdmso_tdm_src #(.N(N), .PAT(PAT)) i_tdmso_tdm_src (
    .link_clk_o(link_clk), .frame_n_o(frm_n), .data_o(rx));
  tdmso_port #(.N(N)) i_tdmso_port (.clk_i(clk), .rst_n_i(rst_n),
    .master_frame_pulse_in_i(frm_n), .link_clk_i(link_clk),
    .rx_stream_i(rx), .output_drive_allow_pin_i(allow),
    .out_drive_select_i(sel), .sample_point_select_flag_i(smode),
    .output_standby_bit_i(stby), .in_rate_i({N{`TDMSO_RATE_16M}}),
    .in_chan_delay_regs_i(icd), .in_bit_offset_field_i(ibo),
    .out_rate_i(orate), .out_advance_regs_i(adv), .tx_bit_i(tx),
    .conn_output_on_bit_i(on), .serial_outputs_o(so),
    .serial_outputs_oe_o(soe), .tristate_ctrl_streams_o(ctrl),
    .rx_byte_o(rbyte), .rx_chan_o(rchan), .rx_valid_o(vld),
    .frame_pulse_out_o(fp));
  always @(negedge clk)
    for (int g = 0; g < 4; g++)
      if (vld[g] && rchan[9*g+:9] < 9'h002)
        got[g][rchan[9*g]] = rbyte[8*g+:8];
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_errors++;
      $display("[ERR] t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("checks %0d errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic do_reset(input logic s);
    @(posedge clk);
    rst_n <= 1'b0;
    sel <= s;
    repeat (6) @(negedge clk);
    chk(so, '1);
    chk(soe, {N{~s}});
    chk(ctrl, 4'h0);
    chk(vld, '0);
    @(posedge clk);
    rst_n <= 1'b1;
    $display("test reset %0d done", s);
  endtask
  task automatic adv_test(input logic [2:0] r, input int step);
    int t [4] = '{default: -1};
    @(posedge clk);
    orate <= {N{r}};
    for (int g = 0; g < 4; g++)
      adv[2*g+:2] <= 2'(g);
    repeat (2) @(posedge fp);
    repeat (20) @(posedge clk);
    tx <= '0;
    @(posedge clk);
    tx <= '1;
    for (int c = 0; c < 24; c++)
    begin
      @(negedge clk);
      for (int g = 0; g < 4; g++)
        if (so[g] === 1'b0 && t[g] < 0)
          t[g] = c;
    end
    for (int g = 1; g < 4; g++)
      chk(t[0] - t[g], g * step);
    chk(soe, '1);
    $display("test advance %0d done", r);
  endtask
  task automatic rx_test(input logic m, input logic [19:0] off,
                         input logic [35:0] dly, input logic [15:0] sh);
    @(posedge clk);
    smode <= m;
    ibo[19:0] <= off;
    icd[35:0] <= dly;
    repeat (2) @(posedge fp);
    got = '{default: '{default: 8'hxx}};
    @(posedge fp);
    for (int g = 0; g < 4; g++)
      for (int k = 0; k < 2; k++)
        chk(got[g][k], PAT[63 - sh[4*g+:4] - 8*k -: 8]);
    $display("test input mode %0d done", m);
  endtask
  initial
  begin
    #250000;
    n_errors++;
    results();
  end
  initial
  begin
    do_reset(1'b0);
    allow <= 1'b1;
    stby <= 1'b1;
    adv_test(`TDMSO_RATE_16M, 2);
    adv_test(`TDMSO_RATE_32M, 1);
    rx_test(1'b0, {5'h0A, 5'h08, 5'h00, 5'h00},
            {9'h001, 9'h000, 9'h001, 9'h000}, 16'hB280);
    rx_test(1'b1, {5'h1C, 5'h0F, 5'h0A, 5'h00}, '0, 16'h7320);
    on <= {8{4'h5}};
    repeat (20) @(posedge clk);
    acc = '0;
    repeat (150)
    begin
      @(negedge clk);
      acc = acc | ctrl;
    end
    chk(acc, 4'h5);
    @(posedge clk);
    tx <= '0;
    on <= '1;
    stby <= 1'b0;
    repeat (4) @(negedge clk);
    chk(ctrl, 4'h0);
    chk(so, {N{1'b1}});
    @(posedge clk);
    stby <= 1'b1;
    allow <= 1'b0;
    repeat (8) @(negedge clk);
    chk(ctrl, 4'h0);
    chk(so, {N{1'b1}});
    @(posedge clk);
    allow <= 1'b1;
    on[1] <= 1'b0;
    repeat (20) @(negedge clk);
    chk({soe[1:0], so[1:0]}, 4'hE);
    do_reset(1'b1);
    repeat (20) @(negedge clk);
    chk({soe[1:0], so[1:0]}, 4'h6);
    @(posedge clk);
    on <= '1;
    repeat (20) @(negedge clk);
    chk(soe, '1);
    $display("test drive control done");
    results();
  end
endmodule // tdmso_port_tb
`default_nettype wire
